/* hw/btsbs_pkg.sv */
// package: opcode fields, phase encoding and reset values for the bit test/set executor
package btsbs_pkg;
    localparam int OPC_W = 14;
    localparam int ADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int DATA_W = 8;
    localparam int FIELD_ADDR_LSB = 0;
    localparam int FIELD_BIT_LSB = 7;
    localparam int FIELD_OP_LSB = 10;
    localparam logic [3:0] OP_BIT_TEST_SKIP_IF_CLEAR = 4'h6;
    localparam logic [3:0] OP_BIT_SET = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
    localparam logic [BIT_W-1:0] BIT_RESET = 3'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [OPC_W-1:0] OPC_RESET = 14'h0000;
    typedef enum logic [1:0] {
        BTSBS_Q1,
        BTSBS_Q2,
        BTSBS_Q3,
        BTSBS_Q4
    } btsbs_phase_t;
    typedef enum logic [1:0] {
        BTSBS_OP_NONE,
        BTSBS_OP_TEST,
        BTSBS_OP_SET
    } btsbs_op_t;
endpackage

/* hw/btsbs_exec.sv */
// module: four-phase executor for bit-test-skip-if-clear and bit-set instructions
`timescale 1ns/1ps

module btsbs_exec (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [btsbs_pkg::OPC_W-1:0] instr_in,
    input wire logic [btsbs_pkg::DATA_W-1:0] rd_data_in,
    output logic [btsbs_pkg::ADDR_W-1:0] addr_out,
    output logic rd_en_out,
    output logic wr_en_out,
    output logic [btsbs_pkg::DATA_W-1:0] wr_data_out,
    output logic [1:0] phase_out,
    output logic squash_out,
    output logic done_out,
    output logic flags_we_out
);
    function automatic btsbs_pkg::btsbs_op_t decode_op(input logic [btsbs_pkg::OPC_W-1:0] w);
        logic [3:0] op;
        op = w[btsbs_pkg::FIELD_OP_LSB +: 4];
        if (op == btsbs_pkg::OP_BIT_TEST_SKIP_IF_CLEAR)
            return btsbs_pkg::BTSBS_OP_TEST;
        else if (op == btsbs_pkg::OP_BIT_SET)
            return btsbs_pkg::BTSBS_OP_SET;
        return btsbs_pkg::BTSBS_OP_NONE;
    endfunction

    btsbs_pkg::btsbs_phase_t phase_reg, phase_next;
    btsbs_pkg::btsbs_op_t op_reg, op_next;
    logic [btsbs_pkg::BIT_W-1:0] bit_reg, bit_next;
    logic [btsbs_pkg::ADDR_W-1:0] addr_reg, addr_next;
    logic [btsbs_pkg::DATA_W-1:0] data_reg, data_next;
    logic rd_reg, rd_next;
    logic wr_reg, wr_next;
    logic skip_pend_reg, skip_pend_next;
    logic squash_reg, squash_next;
    logic done_reg, done_next;
    logic flags_we_reg, flags_we_next;

    always_comb begin
        phase_next = phase_reg;
        op_next = op_reg;
        bit_next = bit_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        rd_next = 1'b0;
        wr_next = 1'b0;
        skip_pend_next = skip_pend_reg;
        squash_next = squash_reg;
        done_next = 1'b0;
        // no direct flag path: status bits change only through the register write
        flags_we_next = 1'b0;
        if (ce_in) begin
            unique case (phase_reg)
                btsbs_pkg::BTSBS_Q1: begin
                    phase_next = btsbs_pkg::BTSBS_Q2;
                    // a squashed cycle decodes nothing and keeps all phases idle
                    squash_next = skip_pend_reg;
                    skip_pend_next = 1'b0;
                    if (skip_pend_reg) begin
                        op_next = btsbs_pkg::BTSBS_OP_NONE;
                    end else begin
                        op_next = decode_op(instr_in);
                        bit_next = instr_in[btsbs_pkg::FIELD_BIT_LSB +: btsbs_pkg::BIT_W];
                        addr_next = instr_in[btsbs_pkg::FIELD_ADDR_LSB +: btsbs_pkg::ADDR_W];
                        rd_next = (decode_op(instr_in) != btsbs_pkg::BTSBS_OP_NONE);
                    end
                end
                btsbs_pkg::BTSBS_Q2: begin
                    phase_next = btsbs_pkg::BTSBS_Q3;
                    // read data is returned on the edge after the strobe
                    if (op_reg != btsbs_pkg::BTSBS_OP_NONE)
                        data_next = rd_data_in;
                end
                btsbs_pkg::BTSBS_Q3: begin
                    phase_next = btsbs_pkg::BTSBS_Q4;
                    if (op_reg == btsbs_pkg::BTSBS_OP_SET) begin
                        data_next = data_reg | (8'h01 << bit_reg);
                        wr_next = 1'b1;
                    end
                    if (op_reg == btsbs_pkg::BTSBS_OP_TEST)
                        skip_pend_next = ~data_reg[bit_reg];
                end
                btsbs_pkg::BTSBS_Q4: begin
                    phase_next = btsbs_pkg::BTSBS_Q1;
                    done_next = (op_reg != btsbs_pkg::BTSBS_OP_NONE) || squash_reg;
                    squash_next = 1'b0;
                end
            endcase
        end else begin
            // strobes and done hold through a stall, so a stall never shortens a pulse
            rd_next = rd_reg;
            wr_next = wr_reg;
            done_next = done_reg;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            phase_reg <= btsbs_pkg::BTSBS_Q1;
            op_reg <= btsbs_pkg::BTSBS_OP_NONE;
            bit_reg <= btsbs_pkg::BIT_RESET;
            addr_reg <= btsbs_pkg::ADDR_RESET;
            data_reg <= btsbs_pkg::DATA_RESET;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            skip_pend_reg <= 1'b0;
            squash_reg <= 1'b0;
            done_reg <= 1'b0;
            flags_we_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            op_reg <= op_next;
            bit_reg <= bit_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            skip_pend_reg <= skip_pend_next;
            squash_reg <= squash_next;
            done_reg <= done_next;
            flags_we_reg <= flags_we_next;
        end
    end

    assign addr_out = addr_reg;
    assign rd_en_out = rd_reg;
    assign wr_en_out = wr_reg;
    assign wr_data_out = data_reg;
    assign phase_out = phase_reg;
    assign squash_out = squash_reg;
    assign done_out = done_reg;
    // held low in a register so that every output leaves a flip-flop
    assign flags_we_out = flags_we_reg;

    sequence s_test_clear;
        ce_in && phase_reg == btsbs_pkg::BTSBS_Q3 && op_reg == btsbs_pkg::BTSBS_OP_TEST
            && !data_reg[bit_reg];
    endsequence

    sequence s_set_q3;
        ce_in && phase_reg == btsbs_pkg::BTSBS_Q3 && op_reg == btsbs_pkg::BTSBS_OP_SET;
    endsequence

    // a word offered in Q1 that is not squashed
    sequence s_word_taken;
        ce_in && phase_reg == btsbs_pkg::BTSBS_Q1 && !skip_pend_reg;
    endsequence

    // the word offered in Q1 right after a clear test
    sequence s_squash_start;
        ce_in && phase_reg == btsbs_pkg::BTSBS_Q1 && skip_pend_reg;
    endsequence

    // last phase of an executed or squashed instruction cycle
    sequence s_cycle_end;
        ce_in && phase_reg == btsbs_pkg::BTSBS_Q4
            && (op_reg != btsbs_pkg::BTSBS_OP_NONE || squash_reg);
    endsequence

    // decode checks
    a_decode_test: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && phase_reg == btsbs_pkg::BTSBS_Q1 && !skip_pend_reg
            && instr_in[13:10] == 4'h6 |=> op_reg == btsbs_pkg::BTSBS_OP_TEST)
        else $error("test pattern not decoded");
    a_decode_set: assert property (@(posedge clk_in) disable iff (rst_in)
        s_word_taken ##0 (instr_in[btsbs_pkg::FIELD_OP_LSB +: 4] == btsbs_pkg::OP_BIT_SET)
            |=> op_reg == btsbs_pkg::BTSBS_OP_SET && rd_reg)
        else $error("set pattern not decoded");
    a_decode_other: assert property (@(posedge clk_in) disable iff (rst_in)
        s_word_taken ##0 (instr_in[btsbs_pkg::FIELD_OP_LSB +: 4] != btsbs_pkg::OP_BIT_SET
            && instr_in[btsbs_pkg::FIELD_OP_LSB +: 4] != btsbs_pkg::OP_BIT_TEST_SKIP_IF_CLEAR)
            |=> op_reg == btsbs_pkg::BTSBS_OP_NONE && !rd_reg)
        else $error("foreign word was executed");

    // skip and squash checks
    a_set_no_skip: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && phase_reg == btsbs_pkg::BTSBS_Q3 && op_reg == btsbs_pkg::BTSBS_OP_TEST
            && data_reg[bit_reg] |=> !skip_pend_reg)
        else $error("set bit caused a skip");
    a_clear_skip: assert property (@(posedge clk_in) disable iff (rst_in)
        s_test_clear |=> skip_pend_reg)
        else $error("clear bit left no skip pending");
    a_skip_squash: assert property (@(posedge clk_in) disable iff (rst_in)
        s_test_clear ##1 (ce_in && phase_reg == btsbs_pkg::BTSBS_Q4) ##1 ce_in
            |=> squash_reg && op_reg == btsbs_pkg::BTSBS_OP_NONE)
        else $error("clear bit did not squash next word");
    a_squash_start: assert property (@(posedge clk_in) disable iff (rst_in)
        s_squash_start |=> squash_reg && !rd_reg && phase_reg == btsbs_pkg::BTSBS_Q2)
        else $error("pending skip did not start a squashed cycle");
    a_squash_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        squash_reg |-> !rd_reg && !wr_reg)
        else $error("squashed cycle made an access");

    // phase and data path checks
    a_set_value: assert property (@(posedge clk_in) disable iff (rst_in)
        s_set_q3 |=> wr_reg && wr_data_out == ($past(data_reg) | (8'h01 << $past(bit_reg))))
        else $error("bit set wrote wrong value");
    a_write_q4: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_reg |-> phase_reg == btsbs_pkg::BTSBS_Q4)
        else $error("write outside fourth phase");
    a_read_q2: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_reg |-> phase_reg == btsbs_pkg::BTSBS_Q2 && !squash_reg)
        else $error("read outside second phase");
    a_read_capture: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && phase_reg == btsbs_pkg::BTSBS_Q2 && op_reg != btsbs_pkg::BTSBS_OP_NONE
            |=> data_reg == $past(rd_data_in))
        else $error("register read not captured in second phase");
    a_addr_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && phase_reg != btsbs_pkg::BTSBS_Q1 |=> $stable(addr_reg))
        else $error("address moved inside an instruction cycle");
    a_freeze_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        !ce_in |=> $stable(phase_reg) && $stable(op_reg) && $stable(data_reg)
            && $stable(skip_pend_reg) && $stable(squash_reg))
        else $error("state moved while clock enable was low");

    // cycle count and flag checks: done marks the end of each executed or squashed instruction cycle
    a_done_cycle: assert property (@(posedge clk_in) disable iff (rst_in)
        s_cycle_end |=> done_reg && !squash_reg && phase_reg == btsbs_pkg::BTSBS_Q1)
        else $error("instruction cycle end not marked");
    a_done_q1: assert property (@(posedge clk_in) disable iff (rst_in)
        done_reg |-> phase_reg == btsbs_pkg::BTSBS_Q1)
        else $error("done outside first phase");
    a_flags_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        !flags_we_out)
        else $error("flags written directly");
endmodule // btsbs_exec

/* bench/tb_top.sv */
// self-checking bench for the bit test/set executor
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    logic clk_in, rst_in, ce_in, rd_en_out, wr_en_out, squash_out, done_out, flags_we_out;
    logic [btsbs_pkg::OPC_W-1:0] instr_in;
    logic [btsbs_pkg::DATA_W-1:0] rd_data_in, wr_data_out;
    logic [btsbs_pkg::ADDR_W-1:0] addr_out;
    logic [1:0] phase_out;
    int num_errors = 0, comparisons = 0, cycles = 0, seed = 32'hf7fc, i;
    logic skip = 1'b0;
    btsbs_exec dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .instr_in(instr_in),
        .rd_data_in(rd_data_in), .addr_out(addr_out), .rd_en_out(rd_en_out),
        .wr_en_out(wr_en_out), .wr_data_out(wr_data_out), .phase_out(phase_out),
        .squash_out(squash_out), .done_out(done_out), .flags_we_out(flags_we_out));
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    function automatic logic [7:0] exp_set(input logic [7:0] old, input logic [2:0] b);
        return old | (8'h01 << b);
    endfunction
    task automatic print_verdict();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one word, entered at a falling edge while phase_out is 0; random ce stalls in between
    task automatic run_word(input logic [3:0] op, input logic [2:0] b, input logic [6:0] a,
        input logic [7:0] d);
        logic dec, st;
        dec = !skip && (op == btsbs_pkg::OP_BIT_TEST_SKIP_IF_CLEAR || op == btsbs_pkg::OP_BIT_SET);
        st = (op == btsbs_pkg::OP_BIT_SET);
        instr_in = {op, b, a};
        rd_data_in = d;
        for (int k = 1; k <= 4; k++) begin
            if ($random(seed) % 4 == 0) begin
                ce_in = 1'b0;
                @(negedge clk_in);
                `CHK(phase_out, 2'(k - 1))
                ce_in = 1'b1;
            end
            @(negedge clk_in);
            `CHK(phase_out, 2'(k % 4))
            `CHK(rd_en_out, dec && k == 1)
            if (dec && k == 1) `CHK(addr_out, a)
            `CHK(wr_en_out, dec && st && k == 3)
            if (dec && st && k == 3) `CHK(wr_data_out, exp_set(d, b))
            `CHK(squash_out, skip && k < 4)
            `CHK(done_out, k == 4 && (dec || skip))
            `CHK(flags_we_out, 1'b0)
        end
        skip = dec && !st && !d[b];
    endtask
    always @(posedge clk_in) begin
        cycles++;
        // about three times the worst-case run length with every phase stalled once
        if (cycles == 8000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        logic [31:0] r;
        rst_in = 1'b1;
        ce_in = 1'b1;
        instr_in = 14'h0000;
        rd_data_in = 8'h00;
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        `CHK(phase_out, 2'h0)
        run_word(4'h5, 3'h7, 7'h7f, 8'h7f);
        run_word(4'h6, 3'h0, 7'h01, 8'hfe);
        run_word(4'h6, 3'h0, 7'h02, 8'h01);
        run_word(4'h6, 3'h3, 7'h03, 8'h08);
        run_word(4'h5, 3'h0, 7'h03, 8'hff);
        run_word(4'h4, 3'h2, 7'h05, 8'h00);
        run_word(4'h7, 3'h1, 7'h06, 8'h00);
        $display("test corner done");
        // reset in mid-run while a skip is pending: the next word must not be squashed
        run_word(4'h6, 3'h5, 7'h11, 8'h00);
        rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        skip = 1'b0;
        `CHK(phase_out, 2'h0)
        `CHK(squash_out, 1'b0)
        `CHK(rd_en_out, 1'b0)
        `CHK(done_out, 1'b0)
        run_word(4'h5, 3'h2, 7'h12, 8'h00);
        $display("test reset done");
        for (i = 0; i < 300; i++) begin
            r = $random(seed);
            run_word(r[1:0] == 2'h0 ? r[5:2] : (r[2] ? 4'h6 : 4'h5), r[8:6], r[15:9], r[23:16]);
        end
        $display("test random done");
        print_verdict();
    end
endmodule // tb_top
